/* File: core/cfto_core.sv */
// Execution core for flag, data transfer and core control instructions
`timescale 1ns/100ps
`include "cfto_params.svh"

module cfto_core (
  // Clock and reset
  input  wire logic                 clock_i,
  input  wire logic                 reset_n_i,
  // Instruction issue
  input  wire logic                 instr_valid_i,
  input  wire cfto_pkg::cfto_instr_t instr_i,
  output logic                      instr_ready_o,
  // Data memory and stack
  output cfto_pkg::cfto_dmem_req_t  dmem_req_o,
  input  wire logic [7:0]           dmem_rdata_i,
  // Program memory
  output cfto_pkg::cfto_pmem_req_t  pmem_req_o,
  input  wire logic [7:0]           pmem_rdata_i,
  // Software register port
  input  wire cfto_pkg::cfto_sw_req_t sw_req_i,
  output logic [7:0]                sw_rdata_o,
  // Core control
  input  wire logic                 wake_i,
  input  wire logic                 debug_en_i,
  output logic                      sleep_o,
  output logic                      wdr_o,
  output logic                      break_o,
  output logic [7:0]                flags_o
);
  import cfto_pkg::*;

  cfto_core_t q;
  cfto_core_t d;

  // Low register of a pointer pair; code 3 falls back to the third pair
  function automatic logic [4:0] ptr_base(input logic [1:0] sel);
    case (sel)
      2'h0:    ptr_base = `CFTO_PTR_X_LO;
      2'h1:    ptr_base = `CFTO_PTR_Y_LO;
      default: ptr_base = `CFTO_PTR_Z_LO;
    endcase
  endfunction

  // Read a 16-bit pointer pair
  function automatic logic [15:0] ptr_get(input logic [31:0][7:0] r, input logic [4:0] b);
    ptr_get = {r[5'(b + 5'h01)], r[b]};
  endfunction

  // Ready only when idle or in the last cycle, and not asleep
  always_comb begin
    instr_ready_o = !q.sleeping && ((q.state == ST_IDLE) || (q.state == ST_FINISH));
  end

  // Outputs straight from the state register
  always_comb begin
    dmem_req_o = q.dmem;
    pmem_req_o = q.pmem;
    sw_rdata_o = q.rdata;
    sleep_o    = q.sleeping;
    wdr_o      = q.watchdog_restart;
    break_o    = q.brk;
    flags_o    = q.flags;
  end

  // Next state: software access, writeback, then the new instruction
  always_comb begin
    logic [4:0]  op;
    logic [4:0]  rsel;
    logic [5:0]  fld;
    logic [4:0]  pb;
    logic [15:0] ptr;
    logic [15:0] addr;
    logic        mem_rd;
    logic        mem_wr;
    logic        ptr_wb;
    op     = instr_i.word[15:11];
    rsel   = instr_i.word[10:6];
    fld    = instr_i.word[5:0];
    pb     = `CFTO_PTR_Z_LO;
    ptr    = 16'h0000;
    addr   = 16'h0000;
    mem_rd = 1'b0;
    mem_wr = 1'b0;
    ptr_wb = 1'b0;
    d = q;
    // Strobes and pulses last one cycle
    d.dmem.we = 1'b0;
    d.dmem.re = 1'b0;
    d.pmem.re = 1'b0;
    d.watchdog_restart     = 1'b0;
    d.brk     = 1'b0;
    d.rdata   = 8'h00;

    // Software read, answered next cycle
    if (sw_req_i.re) begin
      if (sw_req_i.addr[6:5] == 2'h0) begin
        d.rdata = q.regs[sw_req_i.addr[4:0]];
      end else begin
        case (sw_req_i.addr)
          `CFTO_ADDR_FLAGS:  d.rdata = q.flags;
          `CFTO_ADDR_STATUS: d.rdata = {6'h00, q.sleeping, q.state != ST_IDLE};
          `CFTO_ADDR_SP_LO:  d.rdata = q.sp[7:0];
          `CFTO_ADDR_SP_HI:  d.rdata = q.sp[15:8];
          default:           d.rdata = 8'h00;
        endcase
      end
    end

    // Software write; the instruction below overrides it on a clash
    if (sw_req_i.we) begin
      if (sw_req_i.addr[6:5] == 2'h0) begin
        d.regs[sw_req_i.addr[4:0]] = sw_req_i.wdata;
      end else begin
        case (sw_req_i.addr)
          `CFTO_ADDR_FLAGS: d.flags = sw_req_i.wdata;
          `CFTO_ADDR_SP_LO: d.sp[7:0] = sw_req_i.wdata;
          `CFTO_ADDR_SP_HI: d.sp[15:8] = sw_req_i.wdata;
          default:          d.flags = d.flags;
        endcase
      end
    end

    // Sequencing of multi-cycle instructions
    case (q.state)
      ST_ACCESS: begin
        // Program memory needs one more cycle to latch its byte
        d.state = (q.wb == WB_LATCH) ? ST_HOLD : ST_FINISH;
      end
      ST_HOLD: begin
        d.latch = pmem_rdata_i;
        d.state = ST_FINISH;
      end
      ST_FINISH: begin
        // Writeback before decode, so a following instruction sees it
        if (q.wb == WB_DMEM) begin
          d.regs[q.dest] = dmem_rdata_i;
        end else if (q.wb == WB_LATCH) begin
          d.regs[q.dest] = q.latch;
        end
        d.wb    = WB_NONE;
        d.state = ST_IDLE;
      end
      default: begin
        d.state = ST_IDLE;
      end
    endcase

    // Wake from sleep: wake_i clears the sleep state here in the core
    if (wake_i) begin
      d.sleeping = 1'b0;
    end

    // Decode and issue the new instruction
    if (instr_valid_i && instr_ready_o) begin
      case (op)
        `CFTO_OP_FLAG_SET: begin
          d.flags[fld[2:0]] = 1'b1;
        end
        `CFTO_OP_FLAG_CLR: begin
          d.flags[fld[2:0]] = 1'b0;
        end
        `CFTO_OP_RD_IND, `CFTO_OP_WR_IND: begin
          pb     = ptr_base(fld[5:4]);
          ptr    = ptr_get(d.regs, pb);
          mem_rd = (op == `CFTO_OP_RD_IND);
          mem_wr = !mem_rd;
          ptr_wb = 1'b1;
          if (fld[1:0] == `CFTO_MODE_PREDEC) begin
            ptr  = ptr - 16'h0001;
            addr = ptr;
          end else if (fld[1:0] == `CFTO_MODE_POSTINC) begin
            addr = ptr;
            ptr  = ptr + 16'h0001;
          end else begin
            addr = ptr;
          end
        end
        `CFTO_OP_RD_DISP_Y, `CFTO_OP_WR_DISP_Y: begin
          // Pointer itself is left untouched
          pb     = `CFTO_PTR_Y_LO;
          addr   = ptr_get(d.regs, pb) + {10'h000, fld};
          mem_rd = (op == `CFTO_OP_RD_DISP_Y);
          mem_wr = !mem_rd;
        end
        `CFTO_OP_RD_DISP_Z, `CFTO_OP_WR_DISP_Z: begin
          pb     = `CFTO_PTR_Z_LO;
          addr   = ptr_get(d.regs, pb) + {10'h000, fld};
          mem_rd = (op == `CFTO_OP_RD_DISP_Z);
          mem_wr = !mem_rd;
        end
        `CFTO_OP_RD_DIR: begin
          addr   = instr_i.ext;
          mem_rd = 1'b1;
        end
        `CFTO_OP_WR_DIR: begin
          addr   = instr_i.ext;
          mem_wr = 1'b1;
        end
        `CFTO_OP_PUSH: begin
          // Stack grows down: store then decrement
          addr   = d.sp;
          d.sp   = d.sp - 16'h0001;
          mem_wr = 1'b1;
        end
        `CFTO_OP_POP: begin
          d.sp   = d.sp + 16'h0001;
          addr   = d.sp;
          mem_rd = 1'b1;
        end
        `CFTO_OP_PMF: begin
          pb          = `CFTO_PTR_Z_LO;
          ptr         = ptr_get(d.regs, pb);
          d.pmem.addr = ptr;
          d.pmem.re   = 1'b1;
          d.dest      = fld[1] ? rsel : 5'h00;
          d.wb        = WB_LATCH;
          d.state     = ST_ACCESS;
          if (fld[0]) begin
            ptr    = ptr + 16'h0001;
            ptr_wb = 1'b1;
          end
        end
        `CFTO_OP_SLEEP: begin
          d.sleeping = 1'b1;
        end
        `CFTO_OP_WDR: begin
          d.watchdog_restart = 1'b1;
        end
        `CFTO_OP_BREAK: begin
          // Without debug this is a plain no-op
          d.brk = debug_en_i;
        end
        default: begin
          d.wb = d.wb;
        end
      endcase

      // Data memory access goes out in the next cycle
      if (mem_rd || mem_wr) begin
        d.dmem.addr  = addr;
        d.dmem.wdata = d.regs[rsel]; // taken before pointer update
        d.dmem.we    = mem_wr;
        d.dmem.re    = mem_rd;
        d.dest       = rsel;
        d.wb         = mem_rd ? WB_DMEM : WB_NONE;
        d.state      = ST_ACCESS;
      end

      // Pointer update; a load into the pointer itself wins later
      if (ptr_wb) begin
        d.regs[pb]             = ptr[7:0];
        d.regs[5'(pb + 5'h01)] = ptr[15:8];
      end
    end
  end

  // State register
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      q       <= '0;
      q.state <= ST_IDLE;
      q.wb    <= WB_NONE;
      q.flags <= `CFTO_FLAGS_RESET;
      q.sp    <= `CFTO_SP_RESET;
    end else begin
      q <= d;
    end
  end

endmodule // cfto_core

/* File: core/cfto_params.svh */
// Constants of the flag and transfer execution core
// How it works
// - Single-cycle set/clear of interrupt enable and signed test flag.
// - Single-cycle set/clear of the overflow flag, no other flag touched.
// - Single-cycle set/clear of half carry, bit-transfer and zero flags.
// - Indirect read, post-increment: load from pointer, then pointer plus one; two cycles.
// - Indirect read, pre-decrement: pointer minus one, then load; two cycles.
// - Displaced read from second or third pointer plus offset; pointer kept; two cycles.
// - Direct read from address in the instruction; two cycles, flags kept.
// - Indirect write, post-increment: store at pointer, then increment; two cycles.
// - Indirect write, pre-decrement: decrement, then store; two cycles.
// - Displaced write at second or third pointer plus offset; pointer kept.
// - Direct write to address carried in the instruction; two cycles, flags kept.
// - Program memory fetch via third pointer, optional increment, three cycles.
// - Push stores a register onto the stack in two cycles.
// - Pop loads a register from the stack in two cycles.
// - Sleep issues in one cycle and hands over to sleep control.
// - Watchdog restart takes one cycle and pulses the restart request.
// - Debug break acts only while on-chip debug is enabled.
`ifndef CFTO_PARAMS_SVH
`define CFTO_PARAMS_SVH
// Opcode field values, instruction bits 15:11
`define CFTO_OP_NOP       5'h00
`define CFTO_OP_FLAG_SET  5'h01
`define CFTO_OP_FLAG_CLR  5'h02
`define CFTO_OP_RD_IND    5'h03
`define CFTO_OP_WR_IND    5'h04
`define CFTO_OP_RD_DISP_Y 5'h05
`define CFTO_OP_RD_DISP_Z 5'h06
`define CFTO_OP_WR_DISP_Y 5'h07
`define CFTO_OP_WR_DISP_Z 5'h08
`define CFTO_OP_RD_DIR    5'h09
`define CFTO_OP_WR_DIR    5'h0A
`define CFTO_OP_PMF       5'h0B
`define CFTO_OP_PUSH      5'h0C
`define CFTO_OP_POP       5'h0D
`define CFTO_OP_SLEEP     5'h0E
`define CFTO_OP_WDR       5'h0F
`define CFTO_OP_BREAK     5'h10
// Indirect addressing modes, instruction bits 1:0
`define CFTO_MODE_PLAIN   2'h0
`define CFTO_MODE_POSTINC 2'h1
`define CFTO_MODE_PREDEC  2'h2
// Low byte of each pointer pair in the register file
`define CFTO_PTR_X_LO     5'h1A
`define CFTO_PTR_Y_LO     5'h1C
`define CFTO_PTR_Z_LO     5'h1E
// Flag register bit positions
`define CFTO_FLAG_C 3'h0
`define CFTO_FLAG_Z 3'h1
`define CFTO_FLAG_N 3'h2
`define CFTO_FLAG_V 3'h3
`define CFTO_FLAG_S 3'h4
`define CFTO_FLAG_H 3'h5
`define CFTO_FLAG_T 3'h6
`define CFTO_FLAG_I 3'h7
// Software port map; 0x00-0x1F is the register file
`define CFTO_ADDR_FLAGS   7'h20
`define CFTO_ADDR_STATUS  7'h21
`define CFTO_ADDR_SP_LO   7'h22
`define CFTO_ADDR_SP_HI   7'h23
// Reset values
`define CFTO_FLAGS_RESET  8'h00
`define CFTO_SP_RESET     16'hFFFF
`endif

/* File: core/cfto_pkg.sv */
// Types of the flag and transfer execution core
package cfto_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_ACCESS, ST_HOLD, ST_FINISH} cfto_state_t;
  typedef enum logic [1:0] {WB_NONE, WB_DMEM, WB_LATCH} cfto_wb_t;
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
  } cfto_sw_req_t;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        we;
    logic        re;
  } cfto_dmem_req_t;
  typedef struct packed {
    logic [15:0] addr;
    logic        re;
  } cfto_pmem_req_t;
  typedef struct packed {
    logic [15:0] word;
    logic [15:0] ext;
  } cfto_instr_t;
  typedef struct packed {
    cfto_state_t     state;
    cfto_wb_t        wb;
    logic [4:0]      dest;
    logic [7:0]      latch;
    logic [31:0][7:0] regs;
    logic [7:0]      flags;
    logic [15:0]     sp;
    cfto_dmem_req_t  dmem;
    cfto_pmem_req_t  pmem;
    logic [7:0]      rdata;
    logic            sleeping;
    logic            watchdog_restart;
    logic            brk;
  } cfto_core_t;
endpackage

/* File: tb/cfto_core_props.sv */
// Checker of instruction timing and effects at the core ports
`timescale 1ns/100ps
`include "cfto_params.svh"
module cfto_core_props
  import cfto_pkg::*;
(
  input wire logic           clock_i,
  input wire logic           reset_n_i,
  input wire logic           instr_valid_i,
  input wire cfto_instr_t    instr_i,
  input wire logic           instr_ready_o,
  input wire cfto_dmem_req_t dmem_req_o,
  input wire logic [7:0]     dmem_rdata_i,
  input wire cfto_pmem_req_t pmem_req_o,
  input wire logic [7:0]     pmem_rdata_i,
  input wire cfto_sw_req_t   sw_req_i,
  input wire logic [7:0]     sw_rdata_o,
  input wire logic           wake_i,
  input wire logic           debug_en_i,
  input wire logic           sleep_o,
  input wire logic           wdr_o,
  input wire logic           break_o,
  input wire logic [7:0]     flags_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  // Instruction taken this cycle and its opcode
  logic       acc;
  logic [4:0] op;
  assign acc = instr_valid_i && instr_ready_o;
  assign op  = instr_i.word[15:11];
  a_flag_set_only:
    assert property (acc && op == `CFTO_OP_FLAG_SET && !sw_req_i.we
      |=> flags_o == ($past(flags_o) | (8'h01 << $past(instr_i.word[2:0])))) else $error("flag set wrong");
  a_flag_clr_only:
    assert property (acc && op == `CFTO_OP_FLAG_CLR && !sw_req_i.we
      |=> flags_o == ($past(flags_o) & ~(8'h01 << $past(instr_i.word[2:0])))) else $error("flag clear wrong");
  a_load_two_cycles:
    assert property (acc && op inside {`CFTO_OP_RD_IND, `CFTO_OP_RD_DISP_Y, `CFTO_OP_RD_DISP_Z, `CFTO_OP_RD_DIR,
      `CFTO_OP_POP} |=> dmem_req_o.re && !instr_ready_o ##1 instr_ready_o) else $error("load timing wrong");
  a_store_two_cycles:
    assert property (acc && op inside {`CFTO_OP_WR_IND, `CFTO_OP_WR_DISP_Y, `CFTO_OP_WR_DISP_Z, `CFTO_OP_WR_DIR,
      `CFTO_OP_PUSH} |=> dmem_req_o.we && !instr_ready_o ##1 instr_ready_o) else $error("store timing wrong");
  a_direct_addr_used:
    assert property (acc && op inside {`CFTO_OP_RD_DIR, `CFTO_OP_WR_DIR}
      |=> dmem_req_o.addr == $past(instr_i.ext)) else $error("direct address wrong");
  a_fetch_three_cycles:
    assert property (acc && op == `CFTO_OP_PMF
      |=> pmem_req_o.re && !instr_ready_o ##1 !instr_ready_o ##1 instr_ready_o) else $error("fetch timing wrong");
  a_transfer_flags_kept:
    assert property (acc && !sw_req_i.we && op inside {`CFTO_OP_RD_IND, `CFTO_OP_WR_IND, `CFTO_OP_PMF,
      `CFTO_OP_PUSH, `CFTO_OP_POP} |=> $stable(flags_o)) else $error("transfer changed flags");
  a_sleep_holds_issue:
    assert property (acc && op == `CFTO_OP_SLEEP |=> sleep_o && !instr_ready_o) else $error("sleep not entered");
  a_wdr_pulse_out:
    assert property (acc && op == `CFTO_OP_WDR |=> wdr_o) else $error("watchdog restart missing");
  a_break_gated_debug:
    assert property (1'b1 |=> break_o == $past(acc && op == `CFTO_OP_BREAK && debug_en_i))
      else $error("break pulse wrong");
endmodule // cfto_core_props

bind cfto_core cfto_core_props i_props (.clock_i, .reset_n_i, .instr_valid_i, .instr_i, .instr_ready_o,
  .dmem_req_o, .dmem_rdata_i, .pmem_req_o, .pmem_rdata_i, .sw_req_i, .sw_rdata_o, .wake_i, .debug_en_i,
  .sleep_o, .wdr_o, .break_o, .flags_o);

/* File: tb/cfto_mem_model.sv */
// Data, stack and program memory beside the core
`timescale 1ns/100ps
module cfto_mem_model (
  // Clock
  input  wire logic                  clock_i,
  // Requests from the core
  input  wire cfto_pkg::cfto_dmem_req_t dmem_req_i,
  input  wire cfto_pkg::cfto_pmem_req_t pmem_req_i,
  // Read data, one cycle after the strobe
  output logic [7:0]                 dmem_rdata_o,
  output logic [7:0]                 pmem_rdata_o
);
  import cfto_pkg::*;
  logic [7:0] mem_q [0:255];
  // Known fill pattern so the bench can predict reads
  initial begin
    for (int i = 0; i < 256; i++) mem_q[i] = 8'(i) ^ 8'h3C;
    dmem_rdata_o = 8'h00;
    pmem_rdata_o = 8'h00;
  end
  // Data outside the read cycle is inverted each cycle, so a stale byte looks valid only every second cycle
  always @(posedge clock_i) begin
    if (dmem_req_i.we) mem_q[dmem_req_i.addr[7:0]] <= dmem_req_i.wdata;
    dmem_rdata_o <= dmem_req_i.re ? mem_q[dmem_req_i.addr[7:0]] : ~dmem_rdata_o;
    pmem_rdata_o <= pmem_req_i.re ? pmem_req_i.addr[7:0] ^ 8'hA5 : ~pmem_rdata_o;
  end
endmodule // cfto_mem_model

/* File: tb/core_flag_and_transfer_ops_bench.sv */
// Self-checking bench of the flag and transfer core
`timescale 1ns/100ps
`include "cfto_params.svh"
module core_flag_and_transfer_ops_bench;
  import cfto_pkg::*;
  logic clock_i, reset_n_i, instr_valid_i, instr_ready_o, wake_i, debug_en_i, sleep_o, wdr_o, break_o, rd_seen;
  logic [7:0]     flags_o, sw_rdata_o, dmem_rdata_i, pmem_rdata_i;
  cfto_instr_t    instr_i;
  cfto_dmem_req_t dmem_req_o;
  cfto_pmem_req_t pmem_req_o;
  cfto_sw_req_t   sw_req_i;
  logic [7:0]     rd_q [$];
  logic [23:0]    st_q [$];
  logic [1:0]     ctl_q [$];
  int             mismatches, checks;
  cfto_core i_dut (.clock_i, .reset_n_i, .instr_valid_i, .instr_i, .instr_ready_o, .dmem_req_o, .dmem_rdata_i,
    .pmem_req_o, .pmem_rdata_i, .sw_req_i, .sw_rdata_o, .wake_i, .debug_en_i, .sleep_o, .wdr_o, .break_o, .flags_o);
  cfto_mem_model i_mem (.clock_i, .dmem_req_i(dmem_req_o), .pmem_req_i(pmem_req_o), .dmem_rdata_o(dmem_rdata_i),
    .pmem_rdata_o(pmem_rdata_i));
  // Clock at 50 ns
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  function automatic logic [7:0] pat(logic [15:0] a);
    return a[7:0] ^ 8'h3C;
  endfunction
  task automatic check(string what, logic [23:0] exp, logic [23:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Software port access; for reads d is the expected byte
  task automatic sw(logic [6:0] a, logic [7:0] d, logic rd);
    @(posedge clock_i);
    sw_req_i <= '{a, d, !rd, rd};
    if (rd) rd_q.push_back(d);
    @(posedge clock_i);
    sw_req_i <= '0;
  endtask
  task automatic ptr(int p, logic [15:0] v, logic rd);
    sw(7'(26 + 2 * p), v[7:0], rd);
    sw(7'(27 + 2 * p), v[15:8], rd);
  endtask
  // Bounded wait for the core to finish, so a hang cannot stall the run
  task automatic idle();
    int n = 0;
    do begin
      @(negedge clock_i);
      n++;
    end while (instr_ready_o !== 1'b1 && n < 40);
    if (instr_ready_o !== 1'b1) begin
      mismatches++;
      final_report();
    end
  endtask
  task automatic issue(logic [4:0] op, logic [4:0] r, logic [5:0] f, logic [15:0] ext);
    @(posedge clock_i);
    instr_valid_i <= 1'b1;
    instr_i <= '{{op, r, f}, ext};
    idle();
    @(posedge clock_i);
    instr_valid_i <= 1'b0;
    if (op != `CFTO_OP_SLEEP) idle();
  endtask
  // Watcher: oldest note against each read or store that appears
  always @(posedge clock_i) rd_seen <= sw_req_i.re;
  always @(negedge clock_i) begin
    if (rd_seen === 1'b1) check("register read", {16'h0000, rd_q.pop_front()}, {16'h0000, sw_rdata_o});
    if (dmem_req_o.we === 1'b1) check("store", st_q.pop_front(), {dmem_req_o.addr, dmem_req_o.wdata});
    // A stray pulse meets an empty queue and fails
    if (wdr_o === 1'b1 || break_o === 1'b1) check("control pulse", {22'h000000, ctl_q.pop_front()},
      {22'h000000, wdr_o, break_o});
  end
  // Main sequence
  initial begin
    logic [7:0]  r, v;
    logic [15:0] b, a;
    logic [5:0]  q;
    logic [1:0]  s;
    reset_n_i = 1'b0;
    instr_valid_i = 1'b0;
    instr_i = '0;
    sw_req_i = '0;
    wake_i = 1'b0;
    debug_en_i = 1'b0;
    void'($urandom(32'h17028F8D));
    repeat (3) @(posedge clock_i);
    reset_n_i <= 1'b1;
    sw(`CFTO_ADDR_FLAGS, 8'h00, 1);
    sw(`CFTO_ADDR_SP_HI, 8'hFF, 1);
    sw(7'h7F, 8'h00, 1);
    sw(`CFTO_ADDR_STATUS, 8'h00, 1);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      r = 8'($urandom);
      sw(`CFTO_ADDR_FLAGS, r, 0);
      issue(`CFTO_OP_FLAG_SET, 5'd0, 6'(i), 16'h0000);
      sw(`CFTO_ADDR_FLAGS, r | (8'h01 << i), 1);
      issue(`CFTO_OP_FLAG_CLR, 5'd0, 6'(i), 16'h0000);
      sw(`CFTO_ADDR_FLAGS, r & ~(8'h01 << i), 1);
    end
    $display("test flags done");
    // Mode code 3 acts as plain, pointer code 3 as the third pair
    for (int p = 0; p < 3; p++) for (int m = 0; m < 4; m++) begin
      b = {8'h01, 8'($urandom)};
      a = (m == 2) ? 16'(b - 1) : b;
      s = (p == 2 && m == 3) ? 2'h3 : 2'(p);
      ptr(p, b, 0);
      issue(`CFTO_OP_RD_IND, 5'd1, {s, 2'b00, m[1:0]}, 16'h0000);
      sw(7'd1, pat(a), 1);
      ptr(p, (m == 1) ? 16'(b + 1) : a, 1);
      ptr(p, b, 0);
      st_q.push_back({a, pat(a)});
      issue(`CFTO_OP_WR_IND, 5'd1, {s, 2'b00, m[1:0]}, 16'h0000);
      ptr(p, (m == 1) ? 16'(b + 1) : a, 1);
    end
    for (int k = 0; k < 2; k++) begin
      b = {8'h02, 8'($urandom)};
      q = 6'($urandom);
      a = b + 16'(q);
      ptr(k + 1, b, 0);
      issue(5'(`CFTO_OP_RD_DISP_Y + k), 5'd4, q, 16'h0000);
      sw(7'd4, pat(a), 1);
      st_q.push_back({a, pat(a)});
      issue(5'(`CFTO_OP_WR_DISP_Y + k), 5'd4, q, 16'h0000);
      ptr(k + 1, b, 1);
    end
    a = {8'h03, 8'($urandom)};
    issue(`CFTO_OP_RD_DIR, 5'd5, 6'd0, a);
    sw(7'd5, pat(a), 1);
    st_q.push_back({a, pat(a)});
    issue(`CFTO_OP_WR_DIR, 5'd5, 6'd0, a);
    $display("test data transfer done");
    for (int f = 0; f < 4; f++) begin
      b = 16'($urandom);
      ptr(2, b, 0);
      issue(`CFTO_OP_PMF, 5'd6, 6'(f), 16'h0000);
      sw(f[1] ? 7'd6 : 7'd0, b[7:0] ^ 8'hA5, 1);
      ptr(2, f[0] ? 16'(b + 1) : b, 1);
    end
    $display("test program fetch done");
    v = 8'($urandom);
    sw(7'd7, v, 0);
    sw(`CFTO_ADDR_SP_LO, 8'h80, 0);
    sw(`CFTO_ADDR_SP_HI, 8'h00, 0);
    st_q.push_back({16'h0080, v});
    issue(`CFTO_OP_PUSH, 5'd7, 6'd0, 16'h0000);
    sw(`CFTO_ADDR_SP_LO, 8'h7F, 1);
    issue(`CFTO_OP_POP, 5'd8, 6'd0, 16'h0000);
    sw(7'd8, v, 1);
    sw(`CFTO_ADDR_SP_LO, 8'h80, 1);
    $display("test stack done");
    r = 8'($urandom);
    sw(`CFTO_ADDR_FLAGS, r, 0);
    issue(`CFTO_OP_SLEEP, 5'd0, 6'd0, 16'h0000);
    // Asleep and idle: status shows only the sleep bit
    sw(`CFTO_ADDR_STATUS, 8'h02, 1);
    @(negedge clock_i);
    check("sleep output", 24'h000001, {23'h000000, sleep_o});
    @(posedge clock_i);
    wake_i <= 1'b1;
    @(posedge clock_i);
    wake_i <= 1'b0;
    idle();
    ctl_q.push_back(2'b10);
    issue(`CFTO_OP_WDR, 5'd0, 6'd0, 16'h0000);
    issue(`CFTO_OP_NOP, 5'd0, 6'd0, 16'h0000);
    @(posedge clock_i);
    debug_en_i <= 1'b1;
    ctl_q.push_back(2'b01);
    issue(`CFTO_OP_BREAK, 5'd0, 6'd0, 16'h0000);
    @(posedge clock_i);
    debug_en_i <= 1'b0;
    issue(`CFTO_OP_BREAK, 5'd0, 6'd0, 16'h0000);
    sw(`CFTO_ADDR_FLAGS, r, 1);
    $display("test control done");
    repeat (3) @(posedge clock_i);
    check("notes left", 24'h000000, 24'(rd_q.size() + st_q.size() + ctl_q.size()));
    final_report();
  end
endmodule // core_flag_and_transfer_ops_bench
